//--- tcpwm_pkg.sv
package tcpwm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CLK_EN = 8'h00;
   localparam logic [7:0] OFF_START = 8'h04;
   localparam logic [7:0] OFF_STOP = 8'h08;
   localparam logic [7:0] OFF_MASTER_CMP = 8'h0c;
   localparam logic [7:0] OFF_SLAVE_CMP = 8'h10;
   localparam logic [7:0] OFF_SLAVE_MODE = 8'h14;
   localparam logic [7:0] OFF_PRESCALE = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFF_P1_LATCH = 8'h28;
   localparam logic [7:0] OFF_P1_DIR = 8'h2c;
   // Field positions
   localparam int BIT_UNIT0_CLK = 0;
   localparam int BIT_CH0 = 0;
   localparam int BIT_CH3 = 3;
   localparam int BIT_IND = 0;
   localparam int STS_LSB = 8;
   localparam int STS_MSB = 10;
   // Start trigger selection: master interrupt
   localparam logic [2:0] STS_MASTER = 3'b100;
   // Reset values
   localparam logic [15:0] RST_CMP = 16'h0000;
   localparam logic [15:0] RST_SLAVE_MODE = 16'h0409;
   localparam logic [7:0] RST_P1_DIR = 8'hff;
   localparam logic [7:0] RST_P1_LATCH = 8'h00;
   localparam logic [3:0] RST_PRESCALE = 4'h0;
   // Interrupt status bits
   localparam int IRQ_PERIOD = 0;
   localparam int IRQ_SLAVE_END = 1;
   localparam int IRQ_W = 2;
   // Slave channel states
   typedef enum logic [0:0] {TCPWM_IDLE, TCPWM_RUN} tcpwm_state_t;
endpackage : tcpwm_pkg

//--- tcpwm_cnt_if.sv
`timescale 1ns/1ps
// Count channel control and status bundle
interface tcpwm_cnt_if;
   logic tick;
   logic load;
   logic en;
   logic [15:0] cmp;
   logic expire;
   logic [15:0] count;
   modport ctrl (output tick, output load, output en, output cmp, input expire, input count);
   modport chan (input tick, input load, input en, input cmp, output expire, output count);
endinterface : tcpwm_cnt_if

//--- tcpwm_down_counter.sv
`timescale 1ns/1ps
// Down counter that reloads on load and flags its expiry
module tcpwm_down_counter
   import tcpwm_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   tcpwm_cnt_if.chan c
);
   logic [WIDTH-1:0] cnt_r;
   logic exp_r;

   // Count down each tick, reload on request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         exp_r <= 1'b0;
      end else begin
         exp_r <= 1'b0;
         if (!c.en) begin
            cnt_r <= '0;
         end else if (c.load) begin
            cnt_r <= c.cmp;
         end else if (c.tick) begin
            if (cnt_r == '0) begin
               exp_r <= 1'b1; // One pulse at underflow
               cnt_r <= c.cmp;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
   assign c.count = cnt_r;
   assign c.expire = exp_r;
endmodule : tcpwm_down_counter

//--- tcpwm_top.sv
`timescale 1ns/1ps
module tcpwm_top
   import tcpwm_pkg::*;
#(
   parameter int CMP_W = 16
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   output logic pulse_output_pin,
   input wire logic indicator_pin_in,
   output logic indicator_pin_out,
   output logic indicator_pin_oe,
   // Interrupt
   output logic irq
);
   logic timer_unit_clock_gate_r;
   logic [3:0] prescale_r;
   logic [15:0] master_compare_value_r;
   logic [15:0] slave_compare_value_r;
   logic [15:0] slave_mode_r;
   logic [7:0] port1_output_latch_r;
   logic [7:0] port1_direction_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic master_run_r;
   logic slave_en_r;
   logic [15:0] pre_cnt_r;
   logic tick;
   logic [31:0] rdata_nxt;
   logic pin_r;
   logic wr_acc;
   logic rd_acc;
   logic setup_cyc;
   logic [15:0] pre_mask;
   logic [IRQ_W-1:0] irq_evt;
   logic stat_rd;
   logic slave_running;
   logic slave_last_tick;
   tcpwm_state_t slave_state_r;
   tcpwm_cnt_if mst ();
   tcpwm_cnt_if slv ();

   // Write or read completes in the single access cycle
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign setup_cyc = psel && !penable;

   // Address decode shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Start trigger field of a mode word
   function automatic logic [2:0] trig_sel(input logic [15:0] mode);
      trig_sel = mode[STS_MSB:STS_LSB];
   endfunction : trig_sel

   // Clock gate and prescaler; software must enable before programming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_unit_clock_gate_r <= 1'b0;
         prescale_r <= RST_PRESCALE;
      end else if (wr_acc) begin
         if (hit(paddr, OFF_CLK_EN)) begin
            timer_unit_clock_gate_r <= pwdata[BIT_UNIT0_CLK];
         end
         if (hit(paddr, OFF_PRESCALE)) begin
            prescale_r <= pwdata[3:0];
         end
      end
   end

   // Count clock divider: a one-cycle enable, gated off when the unit clock stops
   // It restarts from zero when the gate opens; a channel start with the gate already open keeps the running phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r <= 16'h0000;
      end else if (!timer_unit_clock_gate_r) begin
         pre_cnt_r <= 16'h0000;
      end else begin
         pre_cnt_r <= pre_cnt_r + 16'h0001;
      end
   end
   // Low prescale bits that must all be set; a 2**prescale divide
   assign pre_mask = (16'h0001 << prescale_r) - 16'h0001;
   // A stopped unit never ticks, so no channel can move without its clock
   assign tick = timer_unit_clock_gate_r && ((pre_cnt_r & pre_mask) == pre_mask);

   // Timer data registers, writable only with the clock supplied
   // Writes while the unit has no clock are dropped, as the unit cannot take them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_compare_value_r <= RST_CMP;
         slave_compare_value_r <= RST_CMP;
         slave_mode_r <= RST_SLAVE_MODE;
      end else if (wr_acc && timer_unit_clock_gate_r) begin
         if (hit(paddr, OFF_MASTER_CMP)) begin
            master_compare_value_r <= pwdata[15:0];
         end
         if (hit(paddr, OFF_SLAVE_CMP)) begin
            slave_compare_value_r <= pwdata[15:0]; // Duty step is software's job
         end
         if (hit(paddr, OFF_SLAVE_MODE)) begin
            slave_mode_r <= pwdata[15:0];
         end
      end
   end

   // Start and stop: both channels start only from one write with both bits
   // Closing the clock gate stops both, so a half-started pair cannot survive it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_run_r <= 1'b0;
         slave_en_r <= 1'b0;
      end else if (!timer_unit_clock_gate_r) begin
         master_run_r <= 1'b0;
         slave_en_r <= 1'b0;
      end else if (wr_acc && hit(paddr, OFF_START) && pwdata[BIT_CH0] && pwdata[BIT_CH3]) begin
         master_run_r <= 1'b1;
         slave_en_r <= 1'b1;
      end else if (wr_acc && hit(paddr, OFF_STOP)) begin
         if (pwdata[BIT_CH0]) begin
            master_run_r <= 1'b0;
         end
         if (pwdata[BIT_CH3]) begin
            slave_en_r <= 1'b0;
         end
      end
   end

   // Master: interval mode, period of compare plus one ticks
   assign mst.tick = tick;
   assign mst.load = 1'b0;
   assign mst.en = master_run_r;
   assign mst.cmp = master_compare_value_r;
   tcpwm_down_counter #(.WIDTH(CMP_W)) u_master (
      .pclk(pclk),
      .presetn(presetn),
      .c(mst.chan)
   );

   // Slave: one-count, started by the master interrupt when selected
   assign slave_running = (slave_state_r == TCPWM_RUN);
   assign slv.tick = tick && slave_running;
   assign slv.load = mst.expire && (trig_sel(slave_mode_r) == STS_MASTER);
   assign slv.en = slave_en_r;
   assign slv.cmp = slave_compare_value_r - 16'h0001; // Width of compare ticks
   tcpwm_down_counter #(.WIDTH(CMP_W)) u_slave (
      .pclk(pclk),
      .presetn(presetn),
      .c(slv.chan)
   );

   // The pin drops on the tick that empties the count, not on the expiry flag a cycle later,
   // so the high time is exactly compare ticks
   assign slave_last_tick = slv.tick && (slv.count == '0);

   // Slave one-shot state and pulse pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_state_r <= TCPWM_IDLE;
         pin_r <= 1'b0;
      end else if (!slave_en_r) begin
         slave_state_r <= TCPWM_IDLE;
         pin_r <= 1'b0;
      end else begin
         case (slave_state_r)
            TCPWM_IDLE: begin
               if (slv.load && slave_compare_value_r != RST_CMP) begin
                  slave_state_r <= TCPWM_RUN;
                  pin_r <= 1'b1;
               end
            end
            TCPWM_RUN: begin
               // A compare above the period is retriggered before it ends: the pin stays high
               if (slv.load) begin
                  pin_r <= 1'b1; // Restart valid during count
               end else if (slave_last_tick) begin
                  slave_state_r <= TCPWM_IDLE;
                  pin_r <= 1'b0;
               end
            end
            default: begin
               slave_state_r <= TCPWM_IDLE;
            end
         endcase
      end
   end
   assign pulse_output_pin = pin_r;

   // Port 1 latch and direction
   // Latch writes are kept while the pin is an input, so a level can be set before driving
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port1_output_latch_r <= RST_P1_LATCH;
         port1_direction_r <= RST_P1_DIR;
      end else if (wr_acc) begin
         if (hit(paddr, OFF_P1_LATCH)) begin
            port1_output_latch_r <= pwdata[7:0];
         end
         if (hit(paddr, OFF_P1_DIR)) begin
            port1_direction_r <= pwdata[7:0];
         end
      end
   end

   // Indicator pin registered from latch and direction
   // One cycle of lag keeps both pin outputs straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         indicator_pin_out <= 1'b0;
         indicator_pin_oe <= 1'b0;
      end else begin
         indicator_pin_out <= port1_output_latch_r[BIT_IND];
         indicator_pin_oe <= !port1_direction_r[BIT_IND];
      end
   end

   // Event sources, one per status bit; the slave flag comes from its expiry pulse
   assign irq_evt[IRQ_PERIOD] = mst.expire;
   assign irq_evt[IRQ_SLAVE_END] = slv.expire;
   assign stat_rd = rd_acc && hit(paddr, OFF_IRQ_STAT);

   // Sticky status: hardware set wins over read-clear in the access cycle; an event in the setup cycle misses the read data and is cleared
   for (genvar gi = 0; gi < IRQ_W; gi++) begin : g_stat
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            irq_stat_r[gi] <= 1'b0;
         end else if (irq_evt[gi]) begin
            irq_stat_r[gi] <= 1'b1;
         end else if (stat_rd) begin
            irq_stat_r[gi] <= 1'b0;
         end
      end
   end

   // Mask and level interrupt; the line lags the status by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_acc && hit(paddr, OFF_IRQ_MASK)) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // Read mux; unmapped reads return zero
   // Latch bit 0 returns the pin level while the pin is an input
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         OFF_CLK_EN: rdata_nxt = {31'h0, timer_unit_clock_gate_r};
         OFF_MASTER_CMP: rdata_nxt = {16'h0, master_compare_value_r};
         OFF_SLAVE_CMP: rdata_nxt = {16'h0, slave_compare_value_r};
         OFF_SLAVE_MODE: rdata_nxt = {16'h0, slave_mode_r};
         OFF_PRESCALE: rdata_nxt = {28'h0, prescale_r};
         OFF_STATUS: rdata_nxt = {mst.count, 12'h0, pin_r, slave_state_r == TCPWM_RUN, slave_en_r, master_run_r};
         OFF_IRQ_STAT: rdata_nxt = {30'h0, irq_stat_r};
         OFF_IRQ_MASK: rdata_nxt = {30'h0, irq_mask_r};
         OFF_P1_LATCH: rdata_nxt = {24'h0, port1_output_latch_r[7:1], indicator_pin_oe ? port1_output_latch_r[BIT_IND] : indicator_pin_in};
         OFF_P1_DIR: rdata_nxt = {24'h0, port1_direction_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // APB answer: no wait state, data registered in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_cyc; // Exactly one access cycle per transfer
         pslverr <= 1'b0;
         if (setup_cyc && !pwrite) begin
            prdata <= rdata_nxt;
         end
      end
   end
endmodule : tcpwm_top

//--- tcpwm_led_model.sv
`timescale 1ns/1ps
// Indicator LED and pulse probe on the far side of the pins
module tcpwm_led_model (
   // Pins seen
   input wire logic pclk,
   input wire logic pulse,
   input wire logic drv_level,
   input wire logic drv_en,
   // Observed
   output logic pin_level,
   output logic [15:0] hi_len,
   output logic [15:0] per_len
);
   logic [15:0] hi_cnt = 16'h0000;
   logic [15:0] per_cnt = 16'h0000;
   logic last_q = 1'b0;
   initial hi_len = 16'h0000;
   initial per_len = 16'h0000;
   // No pull on the wire: undriven shows the inverse, not a stale level
   assign pin_level = drv_en ? drv_level : !drv_level;
   // Period from rise to rise, width from rise to fall
   always @(posedge pclk) begin
      last_q <= pulse;
      per_cnt <= per_cnt + 16'h0001;
      if (pulse) hi_cnt <= hi_cnt + 16'h0001;
      if (pulse && !last_q) begin
         per_len <= per_cnt;
         per_cnt <= 16'h0001;
         hi_cnt <= 16'h0001;
      end
      if (!pulse && last_q) hi_len <= hi_cnt;
   end
endmodule : tcpwm_led_model

//--- tcpwm_asserts.sv
`timescale 1ns/1ps
// Port-level checker for the pwm timer
module tcpwm_asserts
   import tcpwm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and interrupt
   input wire logic indicator_pin_out,
   input wire logic indicator_pin_oe,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed accesses of interest
   wire logic acc = psel && penable && pready;
   wire logic dir_wr = acc && pwrite && paddr == OFF_P1_DIR;
   wire logic lat_wr = acc && pwrite && paddr == OFF_P1_LATCH;
   wire logic clr = acc && (pwrite ? paddr == OFF_IRQ_MASK : paddr == OFF_IRQ_STAT);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_unmapped_rd;
      psel && penable && !pwrite && paddr > OFF_P1_DIR;
   endsequence
   chk_setup_answer: assert property (s_setup |=> pready) else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   chk_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
   chk_no_error: assert property (!pslverr) else $error("slave error raised");
   chk_unmapped_zero: assert property (s_unmapped_rd |-> prdata == 32'h0) else $error("unmapped read not zero");
   chk_oe_cause: assert property (!$stable(indicator_pin_oe) |-> $past(dir_wr) || $past(dir_wr, 2))
      else $error("pin enable moved without write");
   chk_out_cause: assert property (!$stable(indicator_pin_out) |-> $past(lat_wr) || $past(lat_wr, 2))
      else $error("pin level moved without write");
   chk_irq_fall: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
      else $error("interrupt dropped without clear");
endmodule : tcpwm_asserts
bind tcpwm_top tcpwm_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .indicator_pin_out(indicator_pin_out), .indicator_pin_oe(indicator_pin_oe), .irq(irq));

//--- tcpwm_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the pwm timer
module testbench;
   import tcpwm_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, pulse, pin_in, pin_out, pin_oe, irq;
   logic [15:0] hi_len, per_len;
   int failures = 0, checks_done = 0;
   always #25 pclk = !pclk;
   tcpwm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_output_pin(pulse), .indicator_pin_in(pin_in), .indicator_pin_out(pin_out),
      .indicator_pin_oe(pin_oe), .irq(irq));
   tcpwm_led_model u_led (.pclk(pclk), .pulse(pulse), .drv_level(pin_out), .drv_en(pin_oe),
      .pin_level(pin_in), .hi_len(hi_len), .per_len(per_len));
   task print_verdict;
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer; waits for ready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request stands until ready is seen at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         print_verdict();
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task t_regs;
      apb(0, OFF_SLAVE_MODE, 0); chk("mode", r, 32'h0409);
      apb(0, OFF_P1_DIR, 0); chk("dir", r, 32'hff);
      apb(0, 8'h3c, 0); chk("unmapped", r, 32'h0);
      apb(1, OFF_MASTER_CMP, 9); apb(0, OFF_MASTER_CMP, 0); chk("gated cmp", r, 32'h0);
   endtask : t_regs
   // Pin outputs follow a write two edges after the access
   task t_port;
      apb(1, OFF_P1_DIR, 32'hfe); apb(1, OFF_P1_LATCH, 1); repeat (2) @(negedge pclk);
      chk("oe", pin_oe, 1'b1); chk("out hi", pin_out, 1'b1);
      apb(1, OFF_P1_LATCH, 0); repeat (2) @(negedge pclk); chk("out lo", pin_out, 1'b0);
      apb(1, OFF_P1_DIR, 32'hff); repeat (2) @(negedge pclk); chk("oe off", pin_oe, 1'b0);
      apb(0, OFF_P1_LATCH, 0); chk("pin read", r[0], 1'b1);
   endtask : t_port
   // Period of 10 ticks, duty stepped 10 to 90 percent, then wrapped
   task t_pwm;
      int n;
      apb(1, OFF_CLK_EN, 1); apb(1, OFF_MASTER_CMP, 9); apb(0, OFF_MASTER_CMP, 0);
      chk("cmp", r, 32'h9);
      apb(1, OFF_SLAVE_CMP, 1); apb(1, OFF_START, 1); apb(0, OFF_STATUS, 0);
      chk("half start", r[0], 1'b0);
      apb(1, OFF_START, 32'h9); apb(0, OFF_STATUS, 0); chk("run", r[0], 1'b1);
      for (int k = 1; k <= 9; k += 2) begin
         apb(1, OFF_SLAVE_CMP, k);
         repeat (30) @(posedge pclk);
         chk("period", per_len, 16'd10);
         chk("width", hi_len, 16'(k));
      end
      apb(1, OFF_SLAVE_CMP, 1);
      repeat (30) @(posedge pclk);
      chk("wrap width", hi_len, 16'd1);
      // Software trigger only: master interrupts must not start the slave
      apb(1, OFF_SLAVE_MODE, 32'h0009);
      repeat (20) @(posedge pclk);
      n = 0;
      repeat (20) begin
         @(negedge pclk);
         if (pulse === 1'b1) n++;
      end
      chk("no trigger", n, 0);
   endtask : t_pwm
   task t_irq;
      int n;
      n = 0;
      apb(1, OFF_IRQ_MASK, 1);
      while (irq !== 1'b1 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      chk("irq up", irq, 1'b1);
      // Stop the master first so no new period lands on the clear
      apb(1, OFF_STOP, 1);
      apb(0, OFF_IRQ_STAT, 0); chk("period flag", r[0], 1'b1);
      @(posedge pclk);
      @(negedge pclk);
      chk("irq clr", irq, 1'b0);
      apb(1, OFF_IRQ_MASK, 0);
      apb(1, OFF_START, 32'h9);
      repeat (30) @(posedge pclk);
      chk("masked", irq, 1'b0);
      apb(0, OFF_IRQ_STAT, 0); chk("flag while masked", r[0], 1'b1);
   endtask : t_irq
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_port();
      t_pwm();
      t_irq();
      print_verdict();
   end
endmodule : testbench
